// File: rtl/sip_consts.svh
// Constants for the serial-in parallel-out shifter
`ifndef SIP_CONSTS_SVH
`define SIP_CONSTS_SVH
`define SIP_STAGES 8
`define SIP_FIFO_DEPTH 8
`define SIP_STAGE_RESET 8'h00
`define SIP_PIN_COUNT 4
`define SIP_PIN_CLK 0
`define SIP_PIN_A 1
`define SIP_PIN_B 2
`define SIP_PIN_CLR 3
`define SIP_PIN_RESET 4'h8
`endif

// File: rtl/sip_pkg.sv
// Types shared by the shifter and its testbench
package sip_pkg;
  typedef logic [7:0] sip_word_t;
  typedef logic [3:0] sip_pins_t;
endpackage

// File: rtl/sip_fifo.sv
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sip_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign wr_ready_out = (count != (AW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  always_comb begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; valid gates it
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
endmodule

// File: rtl/sip_shifter.sv
// Eight-stage serial-in parallel-out shifter with gated serial entry
`timescale 1ns/1ns
`include "sip_consts.svh"
module sip_shifter #(
  parameter int FIFO_DEPTH = `SIP_FIFO_DEPTH
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic shift_clk_in,
  input wire logic ser_a_in,
  input wire logic ser_b_in,
  input wire logic async_clear_n_in,
  output sip_pkg::sip_word_t tap_out,
  output logic tap_first_out,
  output logic tap_seventh_out,
  output logic tap_last_out,
  output sip_pkg::sip_word_t snap_data_out,
  output logic snap_valid_out,
  input wire logic snap_ready_in,
  output logic capture_ready_out
);
  import sip_pkg::*;

  sip_pins_t pins_raw, sync1, sync2, sync3, filt;
  sip_pins_t next_sync1, next_sync2, next_sync3, next_filt;
  sip_word_t stage, next_stage;
  logic shift_ev, clr_ok, entry_bit;
  logic fifo_ready;

  // A bit moves only once the second and third flops agree
  function automatic sip_pins_t settle(input sip_pins_t s2,
                                       input sip_pins_t s3,
                                       input sip_pins_t old);
    settle = (s3 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
  endfunction

  assign pins_raw = {async_clear_n_in, ser_b_in, ser_a_in, shift_clk_in};

  always_comb begin
    next_sync1 = pins_raw;
    next_sync2 = sync1;
    next_sync3 = sync2;
    next_filt = settle(sync2, sync3, filt);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1 <= `SIP_PIN_RESET;
      sync2 <= `SIP_PIN_RESET;
      sync3 <= `SIP_PIN_RESET;
      filt <= `SIP_PIN_RESET;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
      filt <= next_filt;
    end
  end

  // Only a low-to-high move of the filtered clock counts
  assign shift_ev = next_filt[`SIP_PIN_CLK] && !filt[`SIP_PIN_CLK];
  assign clr_ok = next_filt[`SIP_PIN_CLR];
  assign entry_bit = next_filt[`SIP_PIN_A] & next_filt[`SIP_PIN_B];

  always_comb begin
    next_stage = stage;
    if (!clr_ok) begin
      next_stage = `SIP_STAGE_RESET;
    end else if (shift_ev) begin
      next_stage = {stage[`SIP_STAGES-2:0], entry_bit};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      stage <= `SIP_STAGE_RESET;
    end else begin
      stage <= next_stage;
    end
  end

  // The raw clear pin gates the taps so clearing shows with no sync delay
  assign tap_out = stage & {`SIP_STAGES{async_clear_n_in}};
  assign tap_first_out = tap_out[0];
  assign tap_seventh_out = tap_out[`SIP_STAGES-2];
  assign tap_last_out = tap_out[`SIP_STAGES-1];

  // Each shifted word is captured; a full FIFO holds the word pending and the next shift
  // replaces it, so the controller must watch capture_ready_out before clocking again
  logic push_pending, next_push_pending;
  always_comb begin
    next_push_pending = push_pending;
    if (clr_ok && shift_ev) begin
      next_push_pending = 1'b1;
    end else if (fifo_ready) begin
      next_push_pending = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      push_pending <= 1'b0;
    end else begin
      push_pending <= next_push_pending;
    end
  end

  assign capture_ready_out = fifo_ready && !push_pending;

  sip_fifo #(
    .WIDTH(`SIP_STAGES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(stage),
    .wr_valid_in(push_pending),
    .wr_ready_out(fifo_ready),
    .rd_data_out(snap_data_out),
    .rd_valid_out(snap_valid_out),
    .rd_ready_in(snap_ready_in)
  );

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_taps_wide;
    async_clear_n_in |-> (tap_out == stage) && (tap_last_out == stage[7]);
  endproperty
  a_taps_wide: assert property (p_taps_wide)
    else $error("taps do not mirror the stages");

  property p_only_rise;
    (clr_ok && !shift_ev) |=> $stable(stage);
  endproperty
  a_only_rise: assert property (p_only_rise)
    else $error("stages moved without a rising shift clock");

  property p_clear_taps;
    !async_clear_n_in |-> tap_out == 8'h00;
  endproperty
  a_clear_taps: assert property (p_clear_taps)
    else $error("taps not low during clear");

  property p_entry_low;
    (clr_ok && shift_ev && !entry_bit) |=> !stage[0];
  endproperty
  a_entry_low: assert property (p_entry_low)
    else $error("first stage loaded high with a serial input low");

  property p_entry_high;
    (clr_ok && shift_ev && next_filt[1] && next_filt[2]) |=> stage[0];
  endproperty
  a_entry_high: assert property (p_entry_high)
    else $error("first stage not high with both serial inputs high");

  property p_shift_one;
    (clr_ok && shift_ev) |=> stage[7:1] == $past(stage[6:0]);
  endproperty
  a_shift_one: assert property (p_shift_one)
    else $error("stages did not shift by one place");

  property p_hold;
    (async_clear_n_in && clr_ok && !shift_ev) ##1 async_clear_n_in
      |-> $stable(tap_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("taps changed while idle");

  property p_release_low;
    $rose(clr_ok) |-> stage == 8'h00 ##1 ($past(shift_ev) || stage == 8'h00);
  endproperty
  a_release_low: assert property (p_release_low)
    else $error("stages not low after clear release");

  // Clear reaches the stages through the filter, so its delay is allowed
  property p_clear_stage;
    !clr_ok |=> stage == 8'h00;
  endproperty
  a_clear_stage: assert property (p_clear_stage)
    else $error("stages not low under a filtered clear");

  property p_a_low;
    (clr_ok && shift_ev && !next_filt[`SIP_PIN_A]) |=> !stage[0];
  endproperty
  a_a_low: assert property (p_a_low)
    else $error("first stage high with serial input A low");

  property p_b_low;
    (clr_ok && shift_ev && !next_filt[`SIP_PIN_B]) |=> !stage[0];
  endproperty
  a_b_low: assert property (p_b_low)
    else $error("first stage high with serial input B low");

  property p_b_decides;
    (clr_ok && shift_ev && next_filt[`SIP_PIN_A])
      |=> stage[0] == $past(next_filt[`SIP_PIN_B]);
  endproperty
  a_b_decides: assert property (p_b_decides)
    else $error("serial input B did not decide the first stage");

  property p_a_decides;
    (clr_ok && shift_ev && next_filt[`SIP_PIN_B])
      |=> stage[0] == $past(next_filt[`SIP_PIN_A]);
  endproperty
  a_a_decides: assert property (p_a_decides)
    else $error("serial input A did not decide the first stage");

  // Set wins over the FIFO's take, so no shifted word slips past
  property p_capture_set;
    (clr_ok && shift_ev) |=> push_pending;
  endproperty
  a_capture_set: assert property (p_capture_set)
    else $error("shifted word not marked for capture");

  c_release: cover property ($rose(clr_ok));
  c_b_alone: cover property (clr_ok && shift_ev && next_filt[`SIP_PIN_A]
    && !next_filt[`SIP_PIN_B]);
  c_shift: cover property (clr_ok && shift_ev && entry_bit);
  c_clear: cover property ($fell(async_clear_n_in));
  c_full: cover property (!fifo_ready);
endmodule

// File: test/sip_ctrl_model.sv
// Controller model driving the shifter's clock, serial and clear pins
`timescale 1ns/1ns
module sip_ctrl_model (
  input wire logic mclk_in,
  output logic shift_clk_out,
  output logic ser_a_out,
  output logic ser_b_out,
  output logic clear_n_out
);
  initial begin
    shift_clk_out = 1'b0;
    ser_a_out = 1'b0;
    ser_b_out = 1'b0;
    clear_n_out = 1'b1;
  end
  task automatic wait_edges(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Data settles ahead of the rise; after the fall it is flipped on purpose
  task automatic shift(input logic a, input logic b);
    ser_a_out = a;
    ser_b_out = b;
    wait_edges(5);
    shift_clk_out = 1'b1;
    wait_edges(5);
    shift_clk_out = 1'b0;
    wait_edges(2);
    ser_a_out = ~a;
    ser_b_out = ~b;
    wait_edges(3);
  endtask
  task automatic set_clear_n(input logic v);
    wait_edges(1);
    clear_n_out = v;
  endtask
endmodule

// File: test/sip_shifter_tb.sv
// Self-checking bench for the serial-in parallel-out shifter
`timescale 1ns/1ns
module sip_shifter_tb;
  import sip_pkg::*;
  logic mclk_in, rst_n_in, snap_ready_in, sclk, sa, sb, sclr_n;
  logic first, seventh, last, snap_valid, cap_ready;
  sip_word_t taps, snap_data, exp;
  sip_word_t q[$];
  int fails = 0;
  int total_checks = 0;
  sip_ctrl_model ctl_u (.mclk_in(mclk_in), .shift_clk_out(sclk),
    .ser_a_out(sa), .ser_b_out(sb), .clear_n_out(sclr_n));
  sip_shifter #(.FIFO_DEPTH(8)) dut_u (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .shift_clk_in(sclk), .ser_a_in(sa),
    .ser_b_in(sb), .async_clear_n_in(sclr_n), .tap_out(taps),
    .tap_first_out(first), .tap_seventh_out(seventh),
    .tap_last_out(last), .snap_data_out(snap_data),
    .snap_valid_out(snap_valid), .snap_ready_in(snap_ready_in),
    .capture_ready_out(cap_ready));
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  task automatic check(input string what, input sip_word_t e,
                       input sip_word_t g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Shift one bit and compare all taps against the reference
  task automatic shift_and_check(input logic a, input logic b);
    ctl_u.shift(a, b);
    exp = {exp[6:0], a & b};
    check("taps", exp, taps);
    check("first", {7'h00, exp[0]}, {7'h00, first});
    check("seventh", {7'h00, exp[6]}, {7'h00, seventh});
    check("last", {7'h00, exp[7]}, {7'h00, last});
  endtask
  // Eight shifts covering every gate combination, FIFO left unread
  task automatic t_fill();
    for (int i = 0; i < 8; i++) begin
      shift_and_check(i[0] ^ i[2], i[1] | i[2]);
      q.push_back(exp);
    end
    check("capture_ready", 8'h00, {7'h00, cap_ready});
  endtask
  // Pop every captured word in order; ready stays high afterwards so
  // that words captured later drain at once
  task automatic t_drain();
    int n;
    snap_ready_in = 1'b1;
    while (q.size() > 0) begin
      n = 0;
      while (snap_valid !== 1'b1 && n < 10) begin
        @(posedge mclk_in);
        #1;
        n++;
      end
      if (snap_valid !== 1'b1) begin
        fails++;
        report_and_stop();
      end else begin
        check("snap_data", q.pop_front(), snap_data);
        @(posedge mclk_in);
        #1;
      end
    end
    check("snap_valid", 8'h00, {7'h00, snap_valid});
    check("capture_ready", 8'h01, {7'h00, cap_ready});
  endtask
  // Clear over a shift, stay low after release, then restart from zero
  task automatic t_clear();
    ctl_u.set_clear_n(1'b0);
    #1;
    check("taps_clear", 8'h00, taps);
    ctl_u.shift(1'b1, 1'b1);
    check("taps_clear_shift", 8'h00, taps);
    ctl_u.set_clear_n(1'b1);
    ctl_u.wait_edges(10);
    check("taps_released", 8'h00, taps);
    exp = 8'h00;
    shift_and_check(1'b1, 1'b1);
    shift_and_check(1'b1, 1'b0);
  endtask
  initial begin
    rst_n_in = 1'b0;
    snap_ready_in = 1'b0;
    exp = 8'h00;
    repeat (8) @(posedge mclk_in);
    #1;
    rst_n_in = 1'b1;
    ctl_u.wait_edges(2);
    check("taps_reset", 8'h00, taps);
    t_fill();
    t_drain();
    t_clear();
    report_and_stop();
  end
  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge mclk_in);
    fails++;
    report_and_stop();
  end
endmodule
